// ==== hdl/ios_pkg.sv ====
/*
  Constants and types for the integer operand scheduler.
  Assumes a single core clock and a sixteen-entry integer register file.
*/
package ios_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NREG = 16;
  localparam logic [3:0] PC_REG = 4'hf;

  // ----------------------------------------------------------------
  // Execute stages, as counts of cycles from issue
  // ----------------------------------------------------------------
  localparam logic [2:0] STG_NONE = 3'h0;
  localparam logic [2:0] STG_E1 = 3'h1;
  localparam logic [2:0] STG_E2 = 3'h2;
  localparam logic [2:0] STG_E3 = 3'h3;
  localparam logic [2:0] STG_E5 = 3'h5;

  // ----------------------------------------------------------------
  // Least cycle counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_MUL = 4'h2;
  localparam logic [3:0] CYC_MULL = 4'h3;
  localparam logic [3:0] CYC_LD64 = 4'h2;
  localparam logic [3:0] CYC_PC_LOAD = 4'h1;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [2:0] SB_RST = 3'h0;
  localparam logic [3:0] BUSY_RST = 4'h0;

  typedef enum logic [2:0] {
    OP_DP = 3'b000,
    OP_CMP = 3'b001,
    OP_MOV = 3'b010,
    OP_MUL = 3'b011,
    OP_MULL = 3'b100,
    OP_LOAD = 3'b101,
    OP_BRANCH = 3'b110,
    OP_LDM = 3'b111
  } ios_op_t;

  typedef enum logic [2:0] {
    SH_IMM = 3'b000,
    SH_REG = 3'b001,
    SH_SHIMM = 3'b010,
    SH_RRX = 3'b011,
    SH_SHREG = 3'b100
  } ios_shift_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_RRX = 2'b01,
    ST_BUSY = 2'b10
  } ios_state_t;
endpackage

// ==== hdl/ios_sched.sv ====
/*
  Issue-side operand scheduler: a per-register countdown scoreboard
  that holds an instruction until every source it reads can be
  forwarded by the stage that needs it, then issues it and books
  when its own results become available.
  Assumes the request holds stable until accepted, one request per
  cycle, and that all inputs come from logic on the core clock.
*/
module ios_sched
  import ios_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Issue request
  input wire logic i_valid,
  input wire ios_pkg::ios_op_t i_op,
  input wire ios_pkg::ios_shift_t i_shift,
  input wire logic i_cond,
  input wire logic i_set_flags,
  input wire logic i_has_acc,
  input wire logic i_writeback,
  input wire logic i_double,
  input wire logic i_pipe_pref,
  input wire logic [3:0] i_uops,
  // Register numbers
  input wire logic [3:0] i_first_operand_reg,
  input wire logic [3:0] i_second_operand_reg,
  input wire logic [3:0] i_shift_amount_reg,
  input wire logic [3:0] i_dest_reg,
  input wire logic [3:0] i_dest2_reg,
  // Issue answer
  output logic o_ready,
  output logic o_stall,
  output logic o_issue,
  output logic o_pipe_ff,
  output logic [3:0] o_cycles_ff,
  output logic [2:0] o_result_stage_ff,
  output logic o_busy_ff
);
  import ios_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ios_state_t st;
    logic [NREG-1:0][2:0] sb;
    logic [2:0] flags;
    logic [3:0] busy;
    logic rrx_done;
    logic pipe;
    logic [3:0] cyc;
    logic [2:0] res;
  } ios_regs_t;

  ios_regs_t state_ff;
  ios_regs_t nxt_state;

  logic [4:0] use_v;
  logic [4:0][3:0] use_r;
  logic [4:0][2:0] use_s;
  logic [2:0] wr_v;
  logic [2:0][3:0] wr_r;
  logic [2:0][2:0] wr_a;
  logic [2:0] flag_need;
  logic [3:0] cyc;
  logic as_branch;
  logic multi_off;
  logic deps_ok;
  logic rrx_pend;

  // ----------------------------------------------------------------
  // Decode of source and result timing
  // ----------------------------------------------------------------
  always_comb begin
    use_v = '0;
    use_r = '0;
    use_s = '0;
    wr_v = '0;
    wr_r = '0;
    wr_a = '0;
    flag_need = STG_NONE;
    cyc = CYC_ONE;
    multi_off = 1'b1;
    as_branch = (i_op == OP_BRANCH) ||
      ((i_op == OP_DP || i_op == OP_MOV) && i_dest_reg == PC_REG);
    use_r[0] = i_first_operand_reg;
    use_r[1] = i_second_operand_reg;
    use_r[2] = i_shift_amount_reg;
    use_r[3] = i_dest_reg;
    use_r[4] = i_dest2_reg;
    wr_r[0] = i_dest_reg;
    wr_r[1] = i_first_operand_reg;
    wr_r[2] = i_dest2_reg;
    if (as_branch) begin
      // Operands are read early; no register result is booked.
      use_v[0] = (i_op != OP_BRANCH);
      use_s[0] = STG_E1;
      use_v[1] = (i_op != OP_BRANCH) && (i_shift != SH_IMM);
      use_s[1] = STG_E1;
      flag_need = i_cond ? STG_E3 : STG_NONE;
    end else begin
      if (i_cond) begin
        flag_need = STG_E2;
      end
      unique case (i_op)
        OP_DP, OP_CMP: begin
          use_v[0] = 1'b1;
          use_s[0] = STG_E2;
          use_v[1] = (i_shift != SH_IMM);
          use_s[1] = (i_shift == SH_REG) ? STG_E2 : STG_E1;
          use_v[2] = (i_shift == SH_SHREG);
          use_s[2] = STG_E1;
          use_v[3] = i_cond && (i_op == OP_DP);
          use_s[3] = STG_E2;
          wr_v[0] = (i_op == OP_DP);
          wr_a[0] = STG_E2;
        end
        OP_MOV: begin
          use_v[0] = (i_shift != SH_IMM);
          use_s[0] = STG_E1;
          use_v[2] = (i_shift == SH_SHREG);
          use_s[2] = STG_E1;
          use_v[3] = i_cond;
          use_s[3] = STG_E2;
          wr_v[0] = 1'b1;
          wr_a[0] = i_cond ? STG_E2 : STG_E1;
        end
        OP_MUL: begin
          cyc = CYC_MUL;
          use_v[1] = 1'b1;
          use_s[1] = STG_E1;
          use_v[2] = 1'b1;
          use_s[2] = STG_E1;
          use_v[0] = i_has_acc;
          use_s[0] = STG_E2;
          use_v[3] = i_cond;
          use_s[3] = STG_E2;
          wr_v[0] = 1'b1;
          wr_a[0] = STG_E5;
        end
        OP_MULL: begin
          cyc = CYC_MULL;
          use_v[1] = 1'b1;
          use_s[1] = STG_E1;
          use_v[2] = 1'b1;
          use_s[2] = STG_E1;
          use_v[3] = i_has_acc || i_cond;
          use_s[3] = i_has_acc ? STG_E1 : STG_E2;
          use_v[4] = i_has_acc || i_cond;
          use_s[4] = i_has_acc ? STG_E1 : STG_E2;
          wr_v[0] = 1'b1;
          wr_a[0] = STG_E5;
          wr_v[2] = 1'b1;
          wr_a[2] = STG_E5;
        end
        OP_LOAD: begin
          cyc = i_double ? CYC_LD64 : CYC_ONE;
          if (i_dest_reg == PC_REG) begin
            cyc = cyc + CYC_PC_LOAD;
          end
          use_v[0] = 1'b1;
          use_s[0] = STG_E1;
          use_v[1] = (i_shift != SH_IMM);
          use_s[1] = STG_E1;
          use_v[3] = i_cond;
          use_s[3] = STG_E2;
          wr_v[0] = (i_dest_reg != PC_REG);
          wr_a[0] = STG_E3;
          wr_v[1] = i_writeback;
          wr_a[1] = STG_E2;
          wr_v[2] = i_double;
          wr_a[2] = STG_E3;
        end
        OP_LDM: begin
          // Load-multiple results are timed from the first cycle.
          cyc = (i_uops == 4'h0) ? CYC_ONE : i_uops;
          multi_off = 1'b0;
          use_v[0] = 1'b1;
          use_s[0] = STG_E1;
          wr_v[1] = i_writeback;
          wr_a[1] = STG_E2;
        end
        default: begin
          cyc = CYC_ONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Hazard check and issue handshake
  // ----------------------------------------------------------------
  always_comb begin
    deps_ok = (flag_need == STG_NONE) ||
      (state_ff.flags <= flag_need);
    for (int k = 0; k < 5; k++) begin
      // Each source is judged at the first issue cycle.
      if (use_v[k] && state_ff.sb[use_r[k]] > use_s[k]) begin
        deps_ok = 1'b0;
      end
    end
  end

  assign rrx_pend = (i_shift == SH_RRX) && !state_ff.rrx_done &&
    (i_op == OP_DP || i_op == OP_CMP || i_op == OP_MOV);
  assign o_ready = (state_ff.st == ST_RUN) && deps_ok && !rrx_pend;
  assign o_issue = i_valid && o_ready;
  assign o_stall = i_valid && !o_ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    for (int r = 0; r < NREG; r++) begin
      if (state_ff.sb[r] != SB_RST) begin
        nxt_state.sb[r] = state_ff.sb[r] - 3'h1;
      end
    end
    if (state_ff.flags != SB_RST) begin
      nxt_state.flags = state_ff.flags - 3'h1;
    end
    unique case (state_ff.st)
      ST_RUN: begin
        if (i_valid && rrx_pend) begin
          nxt_state.st = ST_RRX;
        end
        if (!i_valid) begin
          // A withdrawn request must not lend its bubble to the next one.
          nxt_state.rrx_done = 1'b0;
        end
      end
      ST_RRX: begin
        // The lone bubble ahead of a rotate-through-carry operand.
        nxt_state.rrx_done = 1'b1;
        nxt_state.st = ST_RUN;
      end
      ST_BUSY: begin
        nxt_state.busy = state_ff.busy - 4'h1;
        if (state_ff.busy == 4'h1) begin
          nxt_state.st = ST_RUN;
        end
      end
      default: begin
        nxt_state.st = ST_RUN;
      end
    endcase
    if (o_issue) begin
      nxt_state.rrx_done = 1'b0;
      nxt_state.pipe = (i_op == OP_MUL || i_op == OP_MULL) ?
        1'b0 : i_pipe_pref;
      nxt_state.cyc = cyc;
      nxt_state.res = wr_v[0] ? wr_a[0] : STG_NONE;
      nxt_state.busy = cyc - 4'h1;
      nxt_state.st = (cyc > CYC_ONE) ? ST_BUSY : ST_RUN;
      if (i_set_flags) begin
        nxt_state.flags = STG_E2 + cyc[2:0] - 3'h2;
      end
      for (int w = 0; w < 3; w++) begin
        if (wr_v[w]) begin
          // Stored one below the stage, plus cyc-1 except for load-multiple, as a consumer is a cycle behind.
          nxt_state.sb[wr_r[w]] = multi_off ?
            wr_a[w] + cyc[2:0] - 3'h2 : wr_a[w] - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_ff <= '{st: ST_RUN, sb: '0, flags: SB_RST, busy: BUSY_RST,
        rrx_done: 1'b0, pipe: 1'b0, cyc: BUSY_RST, res: STG_NONE};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_pipe_ff = state_ff.pipe;
  assign o_cycles_ff = state_ff.cyc;
  assign o_result_stage_ff = state_ff.res;
  assign o_busy_ff = (state_ff.st != ST_RUN);
endmodule

// ==== tb/ios_sched_properties.sv ====
/*
  Port checker for the integer operand scheduler.
  Assumes one core clock and a synchronous active-high reset.
*/
module ios_sched_properties
  import ios_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire ios_pkg::ios_op_t i_op,
  input wire ios_pkg::ios_shift_t i_shift,
  input wire logic i_cond,
  input wire logic i_double,
  input wire logic [3:0] i_dest_reg,
  input wire logic o_issue,
  input wire logic o_pipe_ff,
  input wire logic [3:0] o_cycles_ff,
  input wire logic [2:0] o_result_stage_ff,
  input wire logic o_busy_ff
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  logic mul;
  logic pc;
  logic dp;
  assign mul = i_op == OP_MUL || i_op == OP_MULL;
  assign pc = i_dest_reg == PC_REG;
  assign dp = i_op == OP_DP || i_op == OP_CMP || i_op == OP_MOV;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  AST_MUL_PIPE: assert property (
    o_issue && mul |=> !o_pipe_ff) else $error("Multiply off pipe 0.");
  AST_MULL_TIME: assert property (
    o_issue && i_op == OP_MULL |=> o_cycles_ff == CYC_MULL &&
    o_result_stage_ff == STG_E5) else $error("Long MAC timing wrong.");
  AST_DP_TIME: assert property (
    o_issue && i_op == OP_DP && !pc |=> o_cycles_ff == CYC_ONE &&
    o_result_stage_ff == STG_E2) else $error("DP timing wrong.");
  AST_MOV_STAGE: assert property (
    o_issue && i_op == OP_MOV && !pc |=> o_result_stage_ff ==
    ($past(i_cond) ? STG_E2 : STG_E1)) else $error("Move stage wrong.");
  AST_CMP_NONE: assert property (
    o_issue && i_op == OP_CMP |=> o_result_stage_ff == STG_NONE)
    else $error("Compare booked a result.");
  AST_RRX_BUBBLE: assert property (
    o_issue && dp && i_shift == SH_RRX |-> $past(o_busy_ff))
    else $error("Rotate issued without bubble.");
  AST_PC_LOAD: assert property (
    o_issue && i_op == OP_LOAD && pc && !i_double |=>
    o_cycles_ff == CYC_ONE + CYC_PC_LOAD) else $error("PC load cycles.");
  AST_PC_DP: assert property (
    o_issue && (i_op == OP_DP || i_op == OP_MOV) && pc |=>
    o_result_stage_ff == STG_NONE) else $error("PC write not a branch.");
  AST_MUL_HOLD: assert property (
    o_issue && i_op == OP_MUL |=> o_busy_ff && !o_issue)
    else $error("Multiply occupancy wrong.");
  AST_LD_DOUBLE: assert property (
    o_issue && i_op == OP_LOAD && i_double && !pc |=>
    o_cycles_ff == CYC_LD64) else $error("Double load cycles.");
  AST_BUSY_REFUSE: assert property (
    o_busy_ff |-> !o_issue) else $error("Issued while busy.");
endmodule
bind ios_sched ios_sched_properties u_props (.i_core_clk, .i_reset,
  .i_op, .i_shift, .i_cond, .i_double, .i_dest_reg, .o_issue,
  .o_pipe_ff, .o_cycles_ff, .o_result_stage_ff, .o_busy_ff);

// ==== tb/tb_ios_sched.sv ====
/*
  Self-checking bench for the operand scheduler.
  Assumes the package and the checker are compiled first.
*/
module tb_ios_sched;
  timeunit 1ns;
  timeprecision 1ns;
  import ios_pkg::*;
  // --------------------------------------------------------------
  // Stimulus and wiring
  // --------------------------------------------------------------
  logic clk = 0, rst = 1, vld = 0, cnd = 0, acc = 0, dbl = 0, pp = 0;
  ios_op_t op = OP_DP;
  ios_shift_t sh = SH_REG;
  logic [3:0] rn = 4'h0, rm = 4'h0, rd = 4'h0, r2 = 4'h0;
  logic [3:0] rs = 4'h0, nu = 4'h1;
  logic sf = 0, wb = 0;
  logic rdy, stl, iss, pipe, busy;
  logic [3:0] cyc;
  logic [2:0] stg;
  int mismatches = 0, comparisons = 0, ticks = 0, w;
  ios_op_t ops[3] = '{OP_DP, OP_CMP, OP_MOV};
  ios_sched u_dut (.i_core_clk(clk), .i_reset(rst), .i_valid(vld),
    .i_op(op), .i_shift(sh), .i_cond(cnd), .i_set_flags(sf),
    .i_has_acc(acc), .i_writeback(wb), .i_double(dbl),
    .i_pipe_pref(pp), .i_uops(nu), .i_first_operand_reg(rn),
    .i_second_operand_reg(rm), .i_shift_amount_reg(rs),
    .i_dest_reg(rd), .i_dest2_reg(r2), .o_ready(rdy), .o_stall(stl),
    .o_issue(iss), .o_pipe_ff(pipe), .o_cycles_ff(cyc),
    .o_result_stage_ff(stg), .o_busy_ff(busy));
  initial forever #50 clk = ~clk;
  // A hung wait would otherwise never reach the verdict.
  always @(posedge clk) begin
    ticks++;
    if (ticks > 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %0h wanted %0h", $time, seen, exp);
    end
  endtask
  // --------------------------------------------------------------
  // Request driver, entered and left at a falling edge
  // --------------------------------------------------------------
  task automatic req(input ios_op_t o, input ios_shift_t s,
    input logic [3:0] n, input logic [3:0] m, input logic [3:0] d);
    op = o;
    sh = s;
    rn = n;
    rm = m;
    rd = d;
    vld = 1;
    w = 0;
    #1;
    while (iss !== 1'b1 && w < 20) begin
      @(negedge clk);
      w++;
      #1;
    end
    @(negedge clk);
  endtask
  // Idle long enough for every booked result to drain.
  task automatic gap;
    vld = 0;
    acc = 0;
    cnd = 0;
    dbl = 0;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_fwd;
    req(OP_DP, SH_REG, 4'h1, 4'h2, 4'h0);
    req(OP_DP, SH_REG, 4'h0, 4'h3, 4'h4);
    chk(8'(w), 8'h00);
    pp = 1;
    req(OP_MUL, SH_REG, 4'h1, 4'h2, 4'h5);
    chk(8'(pipe), 8'h00);
    chk({6'h00, rdy, stl}, 8'h01);
    req(OP_DP, SH_REG, 4'h3, 4'h5, 4'h6);
    chk(8'(w), 8'h03);
    gap();
  endtask
  task automatic t_mul;
    for (int a = 0; a < 2; a++) begin
      req(OP_MUL, SH_REG, 4'h1, 4'h2, 4'h7);
      acc = 1'(a);
      req(OP_MUL, SH_REG, 4'h7, 4'h2, 4'h8);
      chk(8'(w), (a == 1) ? 8'h03 : 8'h01);
      gap();
      cnd = 1'(a);
      req(OP_MUL, SH_REG, 4'h1, 4'h2, 4'h8);
      req(OP_DP, SH_IMM, 4'h1, 4'h0, 4'h8);
      chk(8'(w), (a == 1) ? 8'h03 : 8'h01);
      gap();
    end
    acc = 1;
    r2 = 4'ha;
    req(OP_MULL, SH_REG, 4'h1, 4'h2, 4'h9);
    chk({cyc, 1'b0, stg}, {CYC_MULL, 1'b0, STG_E5});
    req(OP_LOAD, SH_IMM, 4'ha, 4'h0, 4'hb);
    chk(8'(w), 8'h05);
    gap();
  endtask
  task automatic t_rrx;
    foreach (ops[i]) begin
      req(ops[i], SH_RRX, 4'h1, 4'h2, 4'h3);
      chk(8'(w), 8'h02);
      gap();
    end
  endtask
  task automatic t_load;
    for (int f = 0; f < 2; f++) begin
      dbl = 1'(f);
      r2 = 4'hc;
      req(OP_LOAD, SH_IMM, 4'h1, 4'h0, 4'hb);
      dbl = 0;
      req(OP_LOAD, SH_IMM, 4'hc, 4'h0, 4'hd);
      chk(8'(w), (f == 1) ? 8'h02 : 8'h00);
      gap();
      req(OP_LOAD, SH_IMM, 4'h1, 4'h0, 4'hb);
      req(OP_DP, SH_SHIMM, f ? 4'hb : 4'h2, f ? 4'h3 : 4'hb, 4'h4);
      chk(8'(w), (f == 1) ? 8'h00 : 8'h01);
      gap();
    end
  endtask
  task automatic t_misc;
    cnd = 1;
    req(OP_MOV, SH_IMM, 4'h0, 4'h0, 4'h5);
    chk(8'(stg), 8'(STG_E2));
    cnd = 0;
    req(OP_MOV, SH_IMM, 4'h0, 4'h0, 4'h5);
    chk(8'(stg), 8'(STG_E1));
    req(OP_CMP, SH_REG, 4'h1, 4'h2, 4'h0);
    chk(8'(stg), 8'(STG_NONE));
    req(OP_LOAD, SH_IMM, 4'h1, 4'h0, PC_REG);
    chk(8'(cyc), 8'(CYC_ONE + CYC_PC_LOAD));
    req(OP_DP, SH_REG, 4'h1, 4'h2, PC_REG);
    chk(8'(stg), 8'(STG_NONE));
    gap();
  endtask
  // Flags and a shift-amount register reach their consumers in time.
  task automatic t_flag;
    sf = 1;
    req(OP_DP, SH_REG, 4'h1, 4'h2, 4'h3);
    sf = 0;
    cnd = 1;
    req(OP_DP, SH_IMM, 4'h1, 4'h0, 4'h4);
    chk(8'(w), 8'h00);
    req(OP_BRANCH, SH_IMM, 4'h0, 4'h0, 4'h0);
    chk({w[3:0], 1'b0, stg}, {4'h0, 1'b0, STG_NONE});
    cnd = 0;
    req(OP_LOAD, SH_IMM, 4'h1, 4'h0, 4'hb);
    rs = 4'hb;
    req(OP_DP, SH_SHREG, 4'h2, 4'h3, 4'h4);
    rs = 4'h0;
    chk(8'(w), 8'h01);
    gap();
  endtask
  // A load-multiple holds issue for one cycle per micro-operation.
  task automatic t_ldm;
    nu = 4'h4;
    wb = 1;
    req(OP_LDM, SH_IMM, 4'h1, 4'h0, 4'h0);
    chk({cyc, busy, stg}, {4'h4, 1'b1, STG_NONE});
    wb = 0;
    req(OP_LOAD, SH_IMM, 4'h1, 4'h0, 4'h5);
    chk(8'(w), 8'h03);
    nu = 4'h1;
    gap();
  endtask
  // A reset in mid-flight clears every booking and the occupancy.
  task automatic t_rst;
    acc = 1;
    req(OP_MULL, SH_REG, 4'h1, 4'h2, 4'h9);
    vld = 0;
    rst = 1;
    @(negedge clk);
    rst = 0;
    chk({busy, stg, cyc}, 8'h00);
    cnd = 1;
    req(OP_MOV, SH_IMM, 4'h0, 4'h0, 4'h9);
    chk({w[3:0], 1'b0, stg}, {4'h0, 1'b0, STG_E2});
    gap();
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    chk({busy, stg, cyc}, 8'h00);
    t_fwd();
    t_mul();
    t_rrx();
    t_load();
    t_misc();
    t_flag();
    t_ldm();
    t_rst();
    summarize();
  end
endmodule
